// ===== rtl/io_assign_pkg.sv
// Purpose: Constants for the servo I/O function assignment block
// Assumes: APB with 32-bit data, one register per aligned word
// Notes:   Function codes are 8 bits wide
package io_assign_pkg;
  // ==========================================
  // Register byte offsets
  localparam logic [7:0] OFF_FORCE_ON    = 8'h00;
  localparam logic [7:0] OFF_IN1_FUNC    = 8'h04;
  localparam logic [7:0] OFF_IN2_FUNC    = 8'h08;
  localparam logic [7:0] OFF_IN3_FUNC    = 8'h0c;
  localparam logic [7:0] OFF_OUT1_FUNC   = 8'h10;
  localparam logic [7:0] OFF_OUT2_FUNC   = 8'h14;
  localparam logic [7:0] OFF_OUT3_FUNC   = 8'h18;
  localparam logic [7:0] OFF_FILTER_SEL  = 8'h1c;
  localparam logic [7:0] OFF_PIN_POL     = 8'h20;
  localparam logic [7:0] OFF_PROX_POL    = 8'h24;
  localparam logic [7:0] OFF_STATUS      = 8'h28;
  // ==========================================
  // Reset values
  localparam logic [3:0] RST_FORCE_ON    = 4'h0;
  localparam logic [7:0] RST_IN1_FUNC    = 8'h0a;
  localparam logic [7:0] RST_IN2_FUNC    = 8'h0b;
  localparam logic [7:0] RST_IN3_FUNC    = 8'h22;
  localparam logic [7:0] RST_OUT1_FUNC   = 8'h05;
  localparam logic [7:0] RST_OUT2_FUNC   = 8'h04;
  localparam logic [7:0] RST_OUT3_FUNC   = 8'h03;
  localparam logic [3:0] RST_FILTER_SEL  = 4'h7;
  localparam logic [7:0] RST_PIN_POL     = 8'h00;
  localparam logic [3:0] RST_PROX_POL    = 4'h0;
  // ==========================================
  // Input function codes
  localparam logic [7:0] FN_FWD_LIMIT    = 8'h0a;
  localparam logic [7:0] FN_REV_LIMIT    = 8'h0b;
  localparam logic [7:0] FN_PROXIMITY    = 8'h22;
  // ==========================================
  // Output function codes
  localparam logic [7:0] FN_FAULT        = 8'h03;
  localparam logic [7:0] FN_POS_REACHED  = 8'h04;
  localparam logic [7:0] FN_BRAKE        = 8'h05;
  // ==========================================
  // Field positions
  localparam int         FORCE_FWD_BIT   = 0;
  localparam int         FORCE_REV_BIT   = 1;
  localparam int         PROX_POL_BIT    = 0;
  localparam int         STAT_FUNC_LSB   = 4;
  // ==========================================
  // Timing: one filter code step, 0.5 ms at 125 MHz
  localparam int         CLK_MHZ         = 125;
  localparam int         FILTER_STEP_US  = 500;
  localparam int         FILTER_STEP_CYC = FILTER_STEP_US * CLK_MHZ;
endpackage

// ===== rtl/input_debounce.sv
// Purpose: Stability filter for one synchronised input
// Assumes: Input already passed two flip-flops
// Notes:   Limit of zero passes the input through
`timescale 1ns/100ps
`default_nettype none
module input_debounce #(
  parameter int CNT_W = 24
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             din,
  input  wire logic [CNT_W-1:0] limit,
  output logic                  dout_q
);
  // ==========================================
  // Stability counter
  logic [CNT_W-1:0] cnt_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q  <= '0;
      dout_q <= 1'b0;
    end else if (din == dout_q) begin
      cnt_q <= '0;
    end else if (cnt_q >= limit) begin
      cnt_q  <= '0;
      dout_q <= din;
    end else begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  a_filter_hold: assert property (@(posedge pclk) disable iff (!presetn)
    (dout_q != $past(dout_q)) |-> ($past(cnt_q) >= $past(limit)))
    else $error("Filtered input changed before stable time");
endmodule // input_debounce
`default_nettype wire

// ===== rtl/servo_io_assign.sv
// Purpose: Function assignment for servo I/O pins, filter and polarity for the input pins
// Assumes: Pins asynchronous to pclk, internal signals on pclk
// Notes:   APB slave, zero wait, one transfer per two cycles
`timescale 1ns/100ps
`default_nettype none
module servo_io_assign #(
  parameter int STEP_CYC = io_assign_pkg::FILTER_STEP_CYC,
  parameter int CNT_W    = 24
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [2:0]  in_pin,
  output logic [2:0]       out_pin,
  input  wire logic        brake_interlock_out,
  input  wire logic        position_reached_out,
  input  wire logic        fault_out,
  output logic             fwd_travel_limit_in,
  output logic             rev_travel_limit_in,
  output logic             proximity_in,
  output logic             fwd_stop,
  output logic             rev_stop
);
  // ==========================================
  // Elaboration check
  if (STEP_CYC < 1 || longint'(STEP_CYC) * 15 >= (longint'(1) << CNT_W)) begin : g_bad_step
    $error("STEP_CYC does not fit the filter counter");
  end

  // ==========================================
  // Configuration registers
  logic [3:0] force_on_select_q;
  logic [7:0] in_func_q [3];
  logic [7:0] out_func_q [3];
  logic [3:0] input_noise_filter_select_q;
  logic [7:0] input_pin_polarity_q;
  logic [3:0] proximity_polarity_q;

  logic       wr_en;
  logic       setup;
  logic [7:0] a;
  assign setup = psel && !penable;
  assign wr_en = psel && penable && pready && pwrite;
  assign a     = paddr;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      force_on_select_q <= io_assign_pkg::RST_FORCE_ON;
    end else if (wr_en && a == io_assign_pkg::OFF_FORCE_ON) begin
      force_on_select_q <= pwdata[3:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      in_func_q[0] <= io_assign_pkg::RST_IN1_FUNC;
      in_func_q[1] <= io_assign_pkg::RST_IN2_FUNC;
      in_func_q[2] <= io_assign_pkg::RST_IN3_FUNC;
    end else if (wr_en) begin
      if (a == io_assign_pkg::OFF_IN1_FUNC) begin
        in_func_q[0] <= pwdata[7:0];
      end
      if (a == io_assign_pkg::OFF_IN2_FUNC) begin
        in_func_q[1] <= pwdata[7:0];
      end
      if (a == io_assign_pkg::OFF_IN3_FUNC) begin
        in_func_q[2] <= pwdata[7:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_func_q[0] <= io_assign_pkg::RST_OUT1_FUNC;
      out_func_q[1] <= io_assign_pkg::RST_OUT2_FUNC;
      out_func_q[2] <= io_assign_pkg::RST_OUT3_FUNC;
    end else if (wr_en) begin
      if (a == io_assign_pkg::OFF_OUT1_FUNC) begin
        out_func_q[0] <= pwdata[7:0];
      end
      if (a == io_assign_pkg::OFF_OUT2_FUNC) begin
        out_func_q[1] <= pwdata[7:0];
      end
      if (a == io_assign_pkg::OFF_OUT3_FUNC) begin
        out_func_q[2] <= pwdata[7:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      input_noise_filter_select_q <= io_assign_pkg::RST_FILTER_SEL;
      input_pin_polarity_q        <= io_assign_pkg::RST_PIN_POL;
      proximity_polarity_q        <= io_assign_pkg::RST_PROX_POL;
    end else if (wr_en) begin
      if (a == io_assign_pkg::OFF_FILTER_SEL) begin
        input_noise_filter_select_q <= pwdata[3:0];
      end
      if (a == io_assign_pkg::OFF_PIN_POL) begin
        input_pin_polarity_q <= pwdata[7:0];
      end
      if (a == io_assign_pkg::OFF_PROX_POL) begin
        proximity_polarity_q <= pwdata[3:0];
      end
    end
  end

  // ==========================================
  // Input path: sync, filter, polarity
  logic [2:0]       sync1_q;
  logic [2:0]       sync2_q;
  logic [2:0]       filt;
  logic [2:0]       pin_on;
  logic [CNT_W-1:0] limit;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_q <= 3'h0;
      sync2_q <= 3'h0;
    end else begin
      sync1_q <= in_pin;
      sync2_q <= sync1_q;
    end
  end

  assign limit = CNT_W'(input_noise_filter_select_q * STEP_CYC);

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_in
      input_debounce #(
        .CNT_W (CNT_W)
      ) u_deb (
        .pclk    (pclk),
        .presetn (presetn),
        .din     (sync2_q[gi]),
        .limit   (limit),
        .dout_q  (filt[gi])
      );
      assign pin_on[gi] = filt[gi] ^ input_pin_polarity_q[gi];
    end
  endgenerate

  // ==========================================
  // Function routing
  logic fwd_pin;
  logic rev_pin;
  logic prox_pin;
  logic prox_used;
  logic fwd_d;
  logic rev_d;
  logic prox_d;

  always_comb begin
    fwd_pin   = 1'b0;
    rev_pin   = 1'b0;
    prox_pin  = 1'b0;
    prox_used = 1'b0;
    for (int i = 0; i < 3; i++) begin
      if (in_func_q[i] == io_assign_pkg::FN_FWD_LIMIT) begin
        fwd_pin = fwd_pin | pin_on[i];
      end
      if (in_func_q[i] == io_assign_pkg::FN_REV_LIMIT) begin
        rev_pin = rev_pin | pin_on[i];
      end
      if (in_func_q[i] == io_assign_pkg::FN_PROXIMITY) begin
        prox_used = 1'b1;
        prox_pin  = prox_pin | pin_on[i];
      end
    end
  end

  // force only on the two limits
  assign fwd_d  = fwd_pin | force_on_select_q[io_assign_pkg::FORCE_FWD_BIT];
  assign rev_d  = rev_pin | force_on_select_q[io_assign_pkg::FORCE_REV_BIT];
  assign prox_d = prox_used &
                  (prox_pin ~^ proximity_polarity_q[io_assign_pkg::PROX_POL_BIT]);

  // stop only when limit is off
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fwd_travel_limit_in <= 1'b0;
      rev_travel_limit_in <= 1'b0;
      proximity_in        <= 1'b0;
      fwd_stop            <= 1'b1;
      rev_stop            <= 1'b1;
    end else begin
      fwd_travel_limit_in <= fwd_d;
      rev_travel_limit_in <= rev_d;
      proximity_in        <= prox_d;
      fwd_stop            <= !fwd_d;
      rev_stop            <= !rev_d;
    end
  end

  // ==========================================
  // Output pin selection
  logic [2:0] out_d;
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      case (out_func_q[i])
        io_assign_pkg::FN_BRAKE:       out_d[i] = brake_interlock_out;
        io_assign_pkg::FN_POS_REACHED: out_d[i] = position_reached_out;
        io_assign_pkg::FN_FAULT:       out_d[i] = fault_out;
        default:                       out_d[i] = 1'b0;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_pin <= 3'h0;
    end else begin
      out_pin <= out_d;
    end
  end

  // ==========================================
  // APB read and answer
  logic [31:0] rd_d;
  logic        hit;
  always_comb begin
    rd_d = 32'h0;
    hit  = 1'b1;
    case (a)
      io_assign_pkg::OFF_FORCE_ON:   rd_d[3:0] = force_on_select_q;
      io_assign_pkg::OFF_IN1_FUNC:   rd_d[7:0] = in_func_q[0];
      io_assign_pkg::OFF_IN2_FUNC:   rd_d[7:0] = in_func_q[1];
      io_assign_pkg::OFF_IN3_FUNC:   rd_d[7:0] = in_func_q[2];
      io_assign_pkg::OFF_OUT1_FUNC:  rd_d[7:0] = out_func_q[0];
      io_assign_pkg::OFF_OUT2_FUNC:  rd_d[7:0] = out_func_q[1];
      io_assign_pkg::OFF_OUT3_FUNC:  rd_d[7:0] = out_func_q[2];
      io_assign_pkg::OFF_FILTER_SEL: rd_d[3:0] = input_noise_filter_select_q;
      io_assign_pkg::OFF_PIN_POL:    rd_d[7:0] = input_pin_polarity_q;
      io_assign_pkg::OFF_PROX_POL:   rd_d[3:0] = proximity_polarity_q;
      io_assign_pkg::OFF_STATUS: begin
        rd_d[2:0] = filt;
        rd_d[io_assign_pkg::STAT_FUNC_LSB +: 3] =
          {proximity_in, rev_travel_limit_in, fwd_travel_limit_in};
      end
      default:                       hit = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= setup;
      pslverr <= setup && !hit;
      prdata  <= (setup && !pwrite) ? rd_d : 32'h0;
    end
  end

  // ==========================================
  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_apb_answer: assert property (setup |=> pready)
    else $error("APB answer not in access phase");
  a_unmapped_err: assert property (setup && !hit |=> pslverr)
    else $error("Unmapped address gave no error");
  a_force_fwd: assert property (
    force_on_select_q[io_assign_pkg::FORCE_FWD_BIT] |=> fwd_travel_limit_in)
    else $error("Forced forward limit not asserted");
  a_force_bypass: assert property (
    force_on_select_q[io_assign_pkg::FORCE_REV_BIT] |=> !rev_stop)
    else $error("Forced reverse limit still stops motion");
  a_no_force_prox: assert property (
    !prox_used |=> !proximity_in)
    else $error("Proximity on without a pin");
  a_unassigned_off: assert property (
    (in_func_q[0] != io_assign_pkg::FN_FWD_LIMIT && in_func_q[1] != io_assign_pkg::FN_FWD_LIMIT
     && in_func_q[2] != io_assign_pkg::FN_FWD_LIMIT
     && !force_on_select_q[io_assign_pkg::FORCE_FWD_BIT]) |=> fwd_stop)
    else $error("Unassigned forward limit read asserted");
  a_out1_route: assert property (
    out_func_q[0] == io_assign_pkg::FN_BRAKE |=> out_pin[0] == $past(brake_interlock_out))
    else $error("Output one does not follow brake interlock");
  a_out2_route: assert property (
    out_func_q[1] == io_assign_pkg::FN_POS_REACHED |=> out_pin[1] == $past(position_reached_out))
    else $error("Output two does not follow position reached");
  a_out3_route: assert property (
    out_func_q[2] == io_assign_pkg::FN_FAULT |=> out_pin[2] == $past(fault_out))
    else $error("Output three does not follow fault");
  a_pol_apply: assert property (
    $changed(input_pin_polarity_q[0]) && $stable(filt[0]) |-> $changed(pin_on[0]))
    else $error("Pin polarity not applied");
  a_stop_pair: assert property (
    fwd_stop == !fwd_travel_limit_in)
    else $error("Stop and limit disagree");

  c_write: cover property (wr_en ##2 wr_en);
  c_force: cover property ($rose(fwd_travel_limit_in) ##1 !fwd_stop);
  c_prox:  cover property ($rose(proximity_in));
endmodule // servo_io_assign
`default_nettype wire

// ===== sim/io_partner.sv
// Purpose: Field switches and loads at the servo I/O pins
// Assumes: Switch levels are requested by the bench on pclk
// Notes:   Loads latch the driven output levels
`timescale 1ns/100ps
`default_nettype none
module io_partner (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic [2:0] sw_level,
  output logic [2:0]      in_pin,
  input  wire logic [2:0] out_pin,
  output logic [2:0]      load_q
);
  // ==========================================
  // Switch contacts
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) in_pin <= 3'h0;
    else in_pin <= sw_level;
  end
  // ==========================================
  // Loads
  always_ff @(posedge pclk) begin
    load_q <= out_pin;
  end
endmodule // io_partner
`default_nettype wire

// ===== sim/servo_io_device_assignment_test.sv
// Purpose: Self-checking bench for the servo I/O assignment block
// Assumes: Short filter step so filter times stay a few cycles
// Notes:   Random pins, codes and polarities from a fixed seed
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin mismatches++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end
module servo_io_device_assignment_test;
  localparam int STEP = 4;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic [7:0]  paddr, pol;
  logic [31:0] pwdata, prdata, rd, r;
  logic [2:0]  in_pin, out_pin, sw_level, load_q;
  logic        brake, pos, fault, fwd, rev, prox, fwd_stop, rev_stop;
  logic [7:0]  fn [3];
  logic [7:0]  ii [3];
  logic [7:0]  oo [3];
  logic [7:0]  codes [4];
  logic [3:0]  frc, ppol;
  int          mismatches, tests_run, cycles;
  integer      seed;
  servo_io_assign #(.STEP_CYC(STEP), .CNT_W(24)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .in_pin(in_pin),
    .out_pin(out_pin), .brake_interlock_out(brake), .position_reached_out(pos), .fault_out(fault),
    .fwd_travel_limit_in(fwd), .rev_travel_limit_in(rev), .proximity_in(prox), .fwd_stop(fwd_stop),
    .rev_stop(rev_stop));
  io_partner partner (.pclk(pclk), .presetn(presetn), .sw_level(sw_level), .in_pin(in_pin),
    .out_pin(out_pin), .load_q(load_q));
  // ==========================================
  // Clock, timeout, verdict
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  task automatic report_and_stop();
    $display("counts: comparisons=%0d mismatches=%0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      report_and_stop();
    end
  end
  // ==========================================
  // Bus and expectations
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input logic ee);
    apb(1'b0, a, 32'h0);
    `CHK(rd, e)
    `CHK(er, ee)
  endtask
  task automatic waitc(input int n);
    repeat (n) @(posedge pclk);
  endtask
  function automatic logic lvl(input logic [7:0] c);
    lvl = 1'b0;
    for (int i = 0; i < 3; i++) if (fn[i] == c && (sw_level[i] ^ pol[i])) lvl = 1'b1;
  endfunction
  function automatic logic used(input logic [7:0] c);
    used = (fn[0] == c) || (fn[1] == c) || (fn[2] == c);
  endfunction
  function automatic logic out_exp(input logic [7:0] c);
    out_exp = (c == io_assign_pkg::FN_FAULT) ? fault : (c == io_assign_pkg::FN_POS_REACHED) ? pos :
              (c == io_assign_pkg::FN_BRAKE) ? brake : 1'b0;
  endfunction
  task automatic chk_inputs();
    logic f, v, p;
    f = frc[0] | lvl(io_assign_pkg::FN_FWD_LIMIT);
    v = frc[1] | lvl(io_assign_pkg::FN_REV_LIMIT);
    p = used(io_assign_pkg::FN_PROXIMITY) & (lvl(io_assign_pkg::FN_PROXIMITY) == ppol[0]);
    `CHK({fwd, rev, prox, fwd_stop, rev_stop}, {f, v, p, ~f, ~v})
    rd_chk(io_assign_pkg::OFF_STATUS, {25'h0, p, v, f, 1'b0, sw_level}, 1'b0);
  endtask
  task automatic cfg();
    for (int i = 0; i < 3; i++) apb(1'b1, ii[i], {24'h0, fn[i]});
    apb(1'b1, io_assign_pkg::OFF_FORCE_ON, {28'h0, frc});
    apb(1'b1, io_assign_pkg::OFF_PIN_POL, {24'h0, pol});
    apb(1'b1, io_assign_pkg::OFF_PROX_POL, {28'h0, ppol});
  endtask
  // ==========================================
  // Main sequence
  initial begin
    seed = 32'hcce9c85b;
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00; pwdata = 32'h0;
    sw_level = 3'h0; brake = 1'b0; pos = 1'b0; fault = 1'b0;
    ii = '{io_assign_pkg::OFF_IN1_FUNC, io_assign_pkg::OFF_IN2_FUNC, io_assign_pkg::OFF_IN3_FUNC};
    oo = '{io_assign_pkg::OFF_OUT1_FUNC, io_assign_pkg::OFF_OUT2_FUNC, io_assign_pkg::OFF_OUT3_FUNC};
    codes = '{8'h03, 8'h04, 8'h05, 8'h7f};
    fn = '{8'h0a, 8'h0b, 8'h22};
    pol = 8'h00; frc = 4'h0; ppol = 4'h0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rd_chk(io_assign_pkg::OFF_FORCE_ON, 32'h0, 1'b0);
    rd_chk(io_assign_pkg::OFF_IN1_FUNC, 32'h0a, 1'b0);
    rd_chk(io_assign_pkg::OFF_IN2_FUNC, 32'h0b, 1'b0);
    rd_chk(io_assign_pkg::OFF_IN3_FUNC, 32'h22, 1'b0);
    rd_chk(io_assign_pkg::OFF_OUT1_FUNC, 32'h05, 1'b0);
    rd_chk(io_assign_pkg::OFF_OUT2_FUNC, 32'h04, 1'b0);
    rd_chk(io_assign_pkg::OFF_OUT3_FUNC, 32'h03, 1'b0);
    rd_chk(io_assign_pkg::OFF_FILTER_SEL, 32'h7, 1'b0);
    rd_chk(io_assign_pkg::OFF_PIN_POL, 32'h0, 1'b0);
    rd_chk(io_assign_pkg::OFF_PROX_POL, 32'h0, 1'b0);
    apb(1'b1, 8'h2c, 32'hffff_ffff);
    `CHK(er, 1'b1)
    rd_chk(8'h2c, 32'h0, 1'b1);
    apb(1'b1, io_assign_pkg::OFF_STATUS, 32'hffff_ffff);
    `CHK(er, 1'b0)
    $display("test registers done");
    sw_level <= 3'b001;
    waitc(20);
    `CHK(fwd, 1'b0)
    waitc(30);
    chk_inputs();
    apb(1'b1, io_assign_pkg::OFF_FILTER_SEL, 32'h2);
    sw_level <= 3'b000;
    waitc(3);
    sw_level <= 3'b001;
    waitc(15);
    `CHK(fwd, 1'b1)
    sw_level <= 3'b000;
    waitc(6);
    `CHK(fwd, 1'b1)
    waitc(14);
    `CHK({fwd, fwd_stop}, 2'b01)
    $display("test filter done");
    apb(1'b1, io_assign_pkg::OFF_FILTER_SEL, 32'h0);
    for (int k = 0; k < 3; k++) begin
      for (int c = 0; c < 4; c++) begin
        apb(1'b1, oo[k], {24'h0, codes[c]});
        r = $random(seed);
        brake <= r[0]; pos <= r[1]; fault <= r[2];
        waitc(4);
        `CHK(load_q[k], out_exp(codes[c]))
      end
      apb(1'b1, oo[k], {24'h0, codes[2 - k]});
    end
    $display("test outputs done");
    for (int t = 0; t < 24; t++) begin
      for (int i = 0; i < 3; i++) begin
        r = $random(seed);
        fn[i] = (t == 0) ? 8'h01 : (r[1:0] == 2'h3) ? 8'h01 : (r[1:0] == 2'h2) ? 8'h22 : {7'h05, r[0]};
      end
      r = $random(seed);
      frc = (t == 0) ? 4'hc : r[3:0];
      ppol = {3'h0, r[4]};
      pol = {5'h0, r[7:5]} & {5'h0, fn[2] == 8'h22 || fn[2] == 8'h01, fn[1] == 8'h22 || fn[1] == 8'h01,
            fn[0] == 8'h22 || fn[0] == 8'h01};
      sw_level <= r[10:8];
      cfg();
      waitc(10);
      chk_inputs();
      rd_chk(io_assign_pkg::OFF_FORCE_ON, {28'h0, frc}, 1'b0);
      rd_chk(ii[t % 3], {24'h0, fn[t % 3]}, 1'b0);
    end
    $display("test random mapping done");
    report_and_stop();
  end
endmodule // servo_io_device_assignment_test
`default_nettype wire
